/* File: tb_top.sv */
// Self-checking bench for the serial port block
`timescale 1ns/10ps
module tb_top;
    reg        clk = 1'b0;
    reg        rst_b = 1'b0;
    reg  [7:0] addr = 8'h00;
    reg  [7:0] wdata = 8'h00;
    reg        wr = 1'b0;
    reg        rd = 1'b0;
    reg        ext_tick16 = 1'b0;
    wire [7:0] rdata;
    wire       txd, rxd_in, rxd_out, rxd_oe_b, irq;
    reg  [7:0] v;
    reg  [9:0] fr;
    int        num_errors = 0;
    int        compares = 0;
    int        n;
    int        f;
    always #25 clk = ~clk;
    // Tick every other cycle, so modes 1 and 3 run 32 cycles a bit
    always @(posedge clk) ext_tick16 <= ~ext_tick16;
    ucd_uart i_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ext_tick16(ext_tick16), .txd(txd), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_oe_b(rxd_oe_b), .irq(irq));
    ucd_remote i_rem (.clk(clk), .txd(txd), .rxd_in(rxd_in));
    task report_and_stop;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input [9:0] seen, input [9:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Strobe dropped and one edge let pass, so back-to-back calls never collide
    task wreg(input [7:0] a, input [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task rchk(input [7:0] a, input [7:0] m, input [7:0] e, input string what);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
        chk({2'h0, v & m}, {2'h0, e}, what);
    endtask
    task wtx(input bit lv);
        n = 0;
        while (txd !== lv) begin
            n++;
            if (n > 4000) begin
                num_errors++;
                report_and_stop;
            end
            @(posedge clk);
        end
    endtask
    // Hang guard
    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rchk(8'h98, 8'hFF, 8'h00, "control");
        rchk(8'hA0, 8'hFF, 8'h00, "config");
        rchk(8'hA2, 8'hFF, 8'h00, "mask");
        rchk(8'h9A, 8'hFF, 8'h00, "unmapped");
        chk({9'h000, txd}, 10'h001, "txd idle");
        $display("test reset done");
        wreg(8'hA2, 8'h03);
        wreg(8'hA0, 8'h02);
        wreg(8'h98, 8'h88);
        wreg(8'h99, 8'hA5);
        wtx(1'b0);
        i_rem.get(fr, 9, 64);
        chk(fr, 10'h3A5, "mode 2 frame");
        chk({9'h000, irq}, 10'h001, "irq");
        rchk(8'h98, 8'hFF, 8'h8A, "tx done");
        rchk(8'hA1, 8'hFF, 8'h01, "status");
        chk({9'h000, irq}, 10'h000, "irq cleared");
        $display("test send done");
        wreg(8'h98, 8'h90);
        i_rem.send(9'h13C, 9, 1'b1, 64);
        rchk(8'h98, 8'hFF, 8'h95, "rx flags");
        rchk(8'h99, 8'hFF, 8'h3C, "rx data");
        rchk(8'hA1, 8'hFF, 8'h02, "status rx");
        wreg(8'h98, 8'h80);
        i_rem.send(9'h0F0, 9, 1'b1, 64);
        rchk(8'h98, 8'h01, 8'h00, "rx off");
        rchk(8'h99, 8'hFF, 8'h3C, "rx data kept");
        $display("test receive done");
        wreg(8'h98, 8'hF0);
        i_rem.send(9'h055, 9, 1'b1, 32);
        rchk(8'h98, 8'h01, 8'h00, "filtered");
        i_rem.send(9'h155, 9, 1'b1, 32);
        rchk(8'h98, 8'h05, 8'h05, "address frame");
        rchk(8'h99, 8'hFF, 8'h55, "address data");
        $display("test filter done");
        wreg(8'h98, 8'h70);
        wreg(8'hA0, 8'h03);
        i_rem.send(9'h0AA, 8, 1'b0, 32);
        for (f = 0; f < 2; f++) rchk(8'h98, 8'h81, 8'h80, "frame error");
        rchk(8'hA1, 8'h04, 8'h04, "status error");
        wreg(8'h98, 8'h70);
        rchk(8'h98, 8'h80, 8'h00, "error cleared");
        i_rem.send(9'h0AA, 8, 1'b1, 32);
        rchk(8'h99, 8'hFF, 8'hAA, "mode 1 data");
        $display("test frame error done");
        wreg(8'hA0, 8'h02);
        wreg(8'hA2, 8'h00);
        rchk(8'hA1, 8'h00, 8'h00, "status drain");
        wreg(8'h98, 8'h80);
        wreg(8'h99, 8'h5A);
        wtx(1'b0);
        i_rem.get(fr, 9, 64);
        chk(fr, 10'h25A, "ninth zero");
        chk({9'h000, irq}, 10'h000, "irq masked");
        wreg(8'hA2, 8'h01);
        chk({9'h000, irq}, 10'h001, "irq unmasked");
        $display("test mask done");
        for (f = 0; f < 2; f++) begin
            wreg(8'h98, f ? 8'h20 : 8'h00);
            wreg(8'h99, 8'hC3);
            wtx(1'b1);
            wtx(1'b0);
            chk({9'h000, rxd_oe_b}, 10'h000, "pin driven");
            chk({9'h000, rxd_out}, 10'h001, "first data bit");
            n = 0;
            while (txd === 1'b0 && n < 20) begin
                n++;
                @(posedge clk);
            end
            chk(n[9:0], f ? 10'h002 : 10'h006, "half period");
            repeat (200) @(posedge clk);
            rchk(8'h98, 8'h02, 8'h02, "mode 0 tx done");
        end
        // Mode 0 receive starts by itself; the idle-high line shifts in all ones
        wreg(8'h98, 8'h10);
        repeat (200) @(posedge clk);
        rchk(8'h98, 8'h01, 8'h01, "mode 0 rx done");
        rchk(8'h99, 8'hFF, 8'hFF, "mode 0 rx data");
        $display("test mode 0 done");
        report_and_stop;
    end
endmodule // tb_top

/* File: ucd_baud_gen.v */
// Rate divider: oversample ticks and synchronous half-bit ticks
`timescale 1ns/10ps
`include "ucd_consts.vh"
module ucd_baud_gen #(
    parameter CW = 5
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // Rate selection
    input  wire [1:0] mode,
    input  wire       fast_sync,
    input  wire       double_rate,
    input  wire       ext_tick16,
    // Enable pulses
    output reg        tick16,
    output reg        half_tick
);
    localparam [31:0] M0_SLOW = `UCD_M0_SLOW_TCLK / 2 - 1;
    localparam [31:0] M0_FAST = `UCD_M0_FAST_TCLK / 2 - 1;
    localparam [31:0] M2_SLOW = `UCD_M2_SLOW_TCLK / `UCD_OVERSAMPLE - 1;
    localparam [31:0] M2_FAST = `UCD_M2_FAST_TCLK / `UCD_OVERSAMPLE - 1;

    reg  [CW-1:0] cnt;
    reg  [CW-1:0] limit;
    wire          wrap;

    // Terminal count per mode
    always @* begin
        if (mode == `UCD_MODE_SYNC) begin
            limit = fast_sync ? M0_FAST[CW-1:0] : M0_SLOW[CW-1:0];
        end else begin
            limit = double_rate ? M2_FAST[CW-1:0] : M2_SLOW[CW-1:0];
        end
    end
    assign wrap = (cnt >= limit);

    // Free-running; a mode change only bends one period
    always @(posedge clk) begin
        if (!rst_b) begin
            cnt       <= {CW{1'b0}};
            tick16    <= 1'b0;
            half_tick <= 1'b0;
        end else begin
            cnt       <= wrap ? {CW{1'b0}} : cnt + 1'b1;
            half_tick <= wrap && (mode == `UCD_MODE_SYNC);
            if (mode == `UCD_MODE_FIXED) begin
                tick16 <= wrap;
            end else begin
                tick16 <= ext_tick16 && (mode != `UCD_MODE_SYNC); // Timer rate
            end
        end
    end
endmodule // ucd_baud_gen

/* File: ucd_consts.vh */
// Register map, field positions, reset values and rate counts of the serial port
`ifndef UCD_CONSTS_VH
`define UCD_CONSTS_VH
// Register addresses
`define UCD_ADDR_CONTROL    8'h98
`define UCD_ADDR_DATA       8'h99
`define UCD_ADDR_CONFIG     8'hA0
`define UCD_ADDR_IRQ_STATUS 8'hA1
`define UCD_ADDR_IRQ_MASK   8'hA2
// Control register fields
`define UCD_CTL_MODE_LO_FE  7
`define UCD_CTL_MODE_HI     6
`define UCD_CTL_ADDR_FILT   5
`define UCD_CTL_RX_EN       4
`define UCD_CTL_TX_NINTH    3
`define UCD_CTL_RX_NINTH    2
`define UCD_CTL_TX_DONE     1
`define UCD_CTL_RX_DONE     0
// Config register fields
`define UCD_CFG_FE_VIEW     0
`define UCD_CFG_IRQ_EN      1
`define UCD_CFG_DOUBLE      2
// Interrupt status and mask fields
`define UCD_IRQ_TX          0
`define UCD_IRQ_RX          1
`define UCD_IRQ_FE          2
// Reset values
`define UCD_RST_CONTROL     8'h00
`define UCD_RST_CONFIG      3'h0
`define UCD_RST_IRQ_MASK    3'h0
// Modes
`define UCD_MODE_SYNC       2'h0
`define UCD_MODE_ASYNC10    2'h1
`define UCD_MODE_FIXED      2'h2
`define UCD_MODE_ASYNC11    2'h3
// Frame lengths in bits
`define UCD_BITS_SYNC       4'h8
`define UCD_BITS_SHORT      4'hA
`define UCD_BITS_LONG       4'hB
// Bit times in oscillator periods, then oversample ticks per bit and the last and sample tick indices
`define UCD_M0_SLOW_TCLK    12
`define UCD_M0_FAST_TCLK    4
`define UCD_M2_SLOW_TCLK    64
`define UCD_M2_FAST_TCLK    32
`define UCD_OVERSAMPLE      16
`define UCD_OS_LAST         4'hF
`define UCD_OS_SAMPLE       4'h7
`endif

/* File: ucd_remote.sv */
// Remote serial device: sends and captures asynchronous frames
`timescale 1ns/10ps
module ucd_remote (
    // Clock
    input  wire clk,
    // Serial lines
    input  wire txd,
    output reg  rxd_in
);
    // Line idles high between frames
    initial rxd_in = 1'b1;
    // Start bit, data LSB first, stop bit, then one idle bit time
    task send(input [8:0] d, input int nb, input bit stp, input int bt);
        int i;
        @(posedge clk) rxd_in <= 1'b0;
        for (i = 0; i < nb; i++) begin
            repeat (bt) @(posedge clk);
            rxd_in <= d[i];
        end
        repeat (bt) @(posedge clk);
        rxd_in <= stp;
        repeat (bt) @(posedge clk);
        rxd_in <= 1'b1;
        repeat (bt) @(posedge clk);
    endtask
    // Called inside the start bit; samples mid bit, stop bit lands in the top position
    task get(output [9:0] d, input int nb, input int bt);
        int i;
        d = 10'h000;
        repeat (bt / 2) @(posedge clk);
        for (i = 0; i <= nb; i++) begin
            repeat (bt) @(posedge clk);
            d[i] = txd;
        end
    endtask
endmodule // ucd_remote

/* File: ucd_uart.v */
// Serial port control register, data buffer, shifters and interrupt
`timescale 1ns/10ps
`include "ucd_consts.vh"
// How it works
// - Control bit 7 shows the low mode bit or the frame error flag, as the view select says.
// - The frame error flag is set by a bad stop bit and holds until software clears it.
// - The two mode bits pick sync 8-bit, async 10-bit, fixed-rate 11-bit or async 11-bit.
// - In modes 2 and 3 with address filtering, a zero ninth bit raises no receive flag.
// - In mode 1 with address filtering, a bad stop bit raises no receive flag.
// - In mode 0 the filter bit picks a shift clock of twelve or four oscillator periods.
// - Frames are received only while the receive enable bit is one.
// - Modes 2 and 3 send the software-written ninth bit as ninth data bit.
// - The received ninth bit holds the ninth data bit or the mode 1 stop bit.
// - The transmit flag rises after bit eight in mode 0 or at the stop bit start.
// - The receive flag rises after bit eight in mode 0 or mid stop bit, if filtering allows.
// - The data address reads the receive register and writes the transmit buffer.
// - A separate enable bit gates the masked status events (transmit, receive, frame error) onto the interrupt.
module ucd_uart #(
    parameter AW = 8,
    parameter DW = 8
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst_b,
    // Register port
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    input  wire          wr,
    input  wire          rd,
    output reg  [DW-1:0] rdata,
    // Oversample tick from the baud timer
    input  wire          ext_tick16,
    // Serial pins
    output reg           txd,
    input  wire          rxd_in,
    output reg           rxd_out,
    output reg           rxd_oe_b,
    // Interrupt
    output wire          irq
);
    // Reset images, so single bits can be picked out at full width
    localparam [7:0] RST_CTL = `UCD_RST_CONTROL;
    localparam [2:0] RST_CFG = `UCD_RST_CONFIG;
    // Control register bits
    reg          mode_select_low;
    reg          frame_error;
    reg          mode_select_high;
    reg          address_filter_enable;
    reg          rx_enable;
    reg          tx_ninth_bit;
    reg          rx_ninth_bit;
    reg          tx_done_flag;
    reg          rx_done_flag;
    // Config register bits
    reg          frame_error_view_select;
    reg          uart_irq_enable;
    reg          double_rate;
    // Interrupt status and mask
    reg  [2:0]   irq_status;
    reg  [2:0]   irq_mask;
    // Receive register
    reg  [7:0]   rx_buf;
    // Transmit and sync-mode shifter
    reg          tx_busy;
    reg          sync_rx;
    reg  [10:0]  tx_shift;
    reg  [3:0]   tx_cnt;
    reg  [3:0]   tx_os;
    reg          sync_phase;
    // Async receiver
    reg          rx_busy;
    reg  [3:0]   rx_os;
    reg  [3:0]   rx_idx;
    reg  [8:0]   rx_shift;
    reg          rxd_prev;
    // Event pulses
    reg          tx_done_set;
    reg          rx_done_set;
    reg          fe_set;
    reg  [7:0]   rx_load_data;
    reg          rx_load_ninth;
    reg          rx_load;
    // Decode and mode
    wire [1:0]   mode;
    wire         is_sync;
    wire         is_short;
    wire [3:0]   frame_bits;
    wire         wr_ctl;
    wire         wr_data;
    wire         wr_cfg;
    wire         wr_mask;
    wire         rd_status;
    wire         tick16;
    wire         half_tick;
    wire         sync_rx_start;
    wire         rx_sample;
    wire [7:0]   rx_data_now;
    wire         rx_accept;

    assign mode       = {mode_select_low, mode_select_high};
    assign is_sync    = (mode == `UCD_MODE_SYNC);
    assign is_short   = (mode == `UCD_MODE_ASYNC10);
    assign frame_bits = is_short ? `UCD_BITS_SHORT : `UCD_BITS_LONG;

    // Strobe decode
    assign wr_ctl    = wr && (addr == `UCD_ADDR_CONTROL);
    assign wr_data   = wr && (addr == `UCD_ADDR_DATA);
    assign wr_cfg    = wr && (addr == `UCD_ADDR_CONFIG);
    assign wr_mask   = wr && (addr == `UCD_ADDR_IRQ_MASK);
    assign rd_status = rd && (addr == `UCD_ADDR_IRQ_STATUS);

    // Rate source for all shifting
    ucd_baud_gen #(
        .CW (5)
    ) u_baud (
        .clk         (clk),
        .rst_b       (rst_b),
        .mode        (mode),
        .fast_sync   (address_filter_enable),
        .double_rate (double_rate),
        .ext_tick16  (ext_tick16),
        .tick16      (tick16),
        .half_tick   (half_tick)
    );

    // Sync receive runs whenever enabled and the last byte was taken
    assign sync_rx_start = is_sync && rx_enable && !rx_done_flag && !tx_busy && !wr_data;

    // Transmitter; also drives the sync clock in both directions
    always @(posedge clk) begin
        if (!rst_b) begin
            tx_busy     <= 1'b0;
            sync_rx     <= 1'b0;
            tx_shift    <= 11'h7FF;
            tx_cnt      <= 4'h0;
            tx_os       <= 4'h0;
            sync_phase  <= 1'b0;
            tx_done_set <= 1'b0;
            txd         <= 1'b1;
            rxd_out     <= 1'b1;
            rxd_oe_b    <= 1'b1;
        end else begin
            tx_done_set <= 1'b0;
            if (wr_data) begin
                // New frame aborts any frame in flight
                tx_busy    <= 1'b1;
                sync_rx    <= 1'b0;
                tx_os      <= 4'h0;
                sync_phase <= 1'b0;
                if (is_sync) begin
                    tx_shift <= {3'h7, wdata};
                    tx_cnt   <= `UCD_BITS_SYNC;
                    rxd_out  <= wdata[0];
                    rxd_oe_b <= 1'b0;
                    txd      <= 1'b1;
                end else begin
                    // Stop, ninth (or the mode 1 stop), data, start
                    tx_shift <= {1'b1, is_short | tx_ninth_bit, wdata, 1'b0};
                    tx_cnt   <= frame_bits;
                    txd      <= 1'b0;
                    rxd_oe_b <= 1'b1;
                end
            end else if (sync_rx_start && !sync_rx) begin
                tx_busy    <= 1'b1;
                sync_rx    <= 1'b1;
                tx_shift   <= 11'h7FF;
                tx_cnt     <= `UCD_BITS_SYNC;
                sync_phase <= 1'b0;
                rxd_oe_b   <= 1'b1;
            end else if (tx_busy && is_sync && half_tick) begin
                if (!sync_phase) begin
                    // Falling half of the shift clock
                    txd        <= 1'b0;
                    sync_phase <= 1'b1;
                end else begin
                    // Rising edge: the partner samples here
                    txd        <= 1'b1;
                    sync_phase <= 1'b0;
                    if (sync_rx) begin
                        tx_shift <= {3'h7, rxd_in, tx_shift[7:1]};
                    end else begin
                        tx_shift <= {1'b1, tx_shift[10:1]};
                    end
                    if (tx_cnt == 4'h1) begin
                        tx_busy     <= 1'b0;
                        sync_rx     <= 1'b0;
                        rxd_oe_b    <= 1'b1;
                        rxd_out     <= 1'b1;
                        tx_done_set <= !sync_rx;
                    end else begin
                        tx_cnt  <= tx_cnt - 4'h1;
                        rxd_out <= tx_shift[1];
                    end
                end
            end else if (tx_busy && !is_sync && tick16) begin
                tx_os <= tx_os + 4'h1;
                if (tx_os == `UCD_OS_LAST) begin
                    if (tx_cnt == 4'h1) begin
                        tx_busy <= 1'b0;
                        txd     <= 1'b1;
                    end else begin
                        tx_shift <= {1'b1, tx_shift[10:1]};
                        txd      <= tx_shift[1];
                        tx_cnt   <= tx_cnt - 4'h1;
                        // Entering the stop bit
                        tx_done_set <= (tx_cnt == 4'h2);
                    end
                end
            end else if (tx_busy && !is_sync && !sync_rx) begin
                txd <= tx_shift[0];
            end
        end
    end

    // Async sample taken mid bit
    assign rx_sample   = rx_busy && tick16 && (rx_os == `UCD_OS_SAMPLE);
    assign rx_data_now = is_short ? rx_shift[8:1] : rx_shift[7:0];
    // Address filter: mode 1 checks stop, modes 2 and 3 check ninth bit
    assign rx_accept   = !rx_done_flag &&
                         (is_short ? !(address_filter_enable && !rxd_in)
                                   : !(address_filter_enable && !rx_shift[8]));

    // Async receiver; a lone start glitch is dropped at its middle
    always @(posedge clk) begin
        if (!rst_b) begin
            rx_busy       <= 1'b0;
            rx_os         <= 4'h0;
            rx_idx        <= 4'h0;
            rx_shift      <= 9'h000;
            rxd_prev      <= 1'b1;
            fe_set        <= 1'b0;
            rx_done_set   <= 1'b0;
            rx_load       <= 1'b0;
            rx_load_data  <= 8'h00;
            rx_load_ninth <= 1'b0;
        end else begin
            rxd_prev    <= rxd_in;
            fe_set      <= 1'b0;
            rx_done_set <= 1'b0;
            rx_load     <= 1'b0;
            if (is_sync) begin
                // Sync receive finishes in the shifter above
                rx_busy <= 1'b0;
                if (tx_busy && sync_rx && half_tick && sync_phase && tx_cnt == 4'h1) begin
                    rx_load      <= 1'b1;
                    rx_done_set  <= 1'b1;
                    rx_load_data <= {rxd_in, tx_shift[7:1]};
                end
            end else if (!rx_enable) begin
                rx_busy <= 1'b0;
            end else if (!rx_busy) begin
                if (rxd_prev && !rxd_in) begin
                    rx_busy <= 1'b1;
                    rx_os   <= 4'h0;
                    rx_idx  <= 4'h0;
                end
            end else if (tick16) begin
                rx_os <= rx_os + 4'h1;
                if (rx_os == `UCD_OS_SAMPLE) begin
                    rx_idx <= rx_idx + 4'h1;
                    if (rx_idx == 4'h0) begin
                        rx_busy <= !rxd_in;
                    end else if (rx_idx == frame_bits - 4'h1) begin
                        // Halfway through the stop bit
                        rx_busy <= 1'b0;
                        fe_set  <= !rxd_in;
                        if (rx_accept) begin
                            rx_load       <= 1'b1;
                            rx_done_set   <= 1'b1;
                            rx_load_data  <= rx_data_now;
                            rx_load_ninth <= is_short ? rxd_in : rx_shift[8];
                        end
                    end else begin
                        rx_shift <= {rxd_in, rx_shift[8:1]};
                    end
                end
            end
        end
    end

    // Receive register and received ninth bit
    always @(posedge clk) begin
        if (!rst_b) begin
            rx_buf       <= 8'h00;
            rx_ninth_bit <= 1'b0;
        end else begin
            if (rx_load) begin
                rx_buf <= rx_load_data;
            end
            if (rx_load && !is_sync) begin
                rx_ninth_bit <= rx_load_ninth;
            end else if (wr_ctl) begin
                rx_ninth_bit <= wdata[`UCD_CTL_RX_NINTH];
            end
        end
    end

    // Control register; hardware set beats a same-cycle clear
    always @(posedge clk) begin
        if (!rst_b) begin
            mode_select_low       <= RST_CTL[`UCD_CTL_MODE_LO_FE];
            frame_error           <= 1'b0;
            mode_select_high      <= 1'b0;
            address_filter_enable <= 1'b0;
            rx_enable             <= 1'b0;
            tx_ninth_bit          <= 1'b0;
            tx_done_flag          <= 1'b0;
            rx_done_flag          <= 1'b0;
        end else begin
            if (wr_ctl) begin
                if (!frame_error_view_select) begin
                    mode_select_low <= wdata[`UCD_CTL_MODE_LO_FE];
                end
                mode_select_high      <= wdata[`UCD_CTL_MODE_HI];
                address_filter_enable <= wdata[`UCD_CTL_ADDR_FILT];
                rx_enable             <= wdata[`UCD_CTL_RX_EN];
                tx_ninth_bit          <= wdata[`UCD_CTL_TX_NINTH];
            end
            // Only software clears, through the shared bit 7
            if (fe_set) begin
                frame_error <= 1'b1;
            end else if (wr_ctl && frame_error_view_select) begin
                frame_error <= wdata[`UCD_CTL_MODE_LO_FE];
            end
            if (tx_done_set) begin
                tx_done_flag <= 1'b1;
            end else if (wr_ctl) begin
                tx_done_flag <= wdata[`UCD_CTL_TX_DONE];
            end
            if (rx_done_set) begin
                rx_done_flag <= 1'b1;
            end else if (wr_ctl) begin
                rx_done_flag <= wdata[`UCD_CTL_RX_DONE];
            end
        end
    end

    // Config and mask registers
    always @(posedge clk) begin
        if (!rst_b) begin
            frame_error_view_select <= RST_CFG[`UCD_CFG_FE_VIEW];
            uart_irq_enable         <= 1'b0;
            double_rate             <= 1'b0;
            irq_mask                <= `UCD_RST_IRQ_MASK;
        end else begin
            if (wr_cfg) begin
                frame_error_view_select <= wdata[`UCD_CFG_FE_VIEW];
                uart_irq_enable         <= wdata[`UCD_CFG_IRQ_EN];
                double_rate             <= wdata[`UCD_CFG_DOUBLE];
            end
            if (wr_mask) begin
                irq_mask <= wdata[2:0];
            end
        end
    end

    // Sticky events; a read clears, but a new event in that cycle stays
    always @(posedge clk) begin
        if (!rst_b) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (irq_status & {3{!rd_status}}) |
                          {fe_set, rx_done_set, tx_done_set};
        end
    end

    // Enable gates everything, so polling software sees no stray line
    assign irq = uart_irq_enable && |(irq_status & irq_mask);

    // Read data, valid only in the cycle after the strobe
    always @(posedge clk) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `UCD_ADDR_CONTROL: begin
                    rdata <= {frame_error_view_select ? frame_error : mode_select_low,
                              mode_select_high, address_filter_enable, rx_enable,
                              tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
                end
                `UCD_ADDR_DATA: begin
                    rdata <= rx_buf;
                end
                `UCD_ADDR_CONFIG: begin
                    rdata <= {5'h00, double_rate, uart_irq_enable, frame_error_view_select};
                end
                `UCD_ADDR_IRQ_STATUS: begin
                    rdata <= {5'h00, irq_status};
                end
                `UCD_ADDR_IRQ_MASK: begin
                    rdata <= {5'h00, irq_mask};
                end
                default: begin
                    rdata <= 8'h00;
                end
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule // ucd_uart

/* File: ucd_uart_asserts.sv */
// Port-level checks of the serial port block
`timescale 1ns/10ps
module ucd_uart_asserts #(
    parameter AW = 8,
    parameter DW = 8
) (
    // Clock and reset
    input wire          clk,
    input wire          rst_b,
    // Register port
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    input wire          wr,
    input wire          rd,
    input wire [DW-1:0] rdata,
    // Serial side and interrupt
    input wire          ext_tick16,
    input wire          txd,
    input wire          rxd_in,
    input wire          rxd_out,
    input wire          rxd_oe_b,
    input wire          irq
);
    reg  [4:0] sh;
    reg  [2:0] cfg;
    reg  [2:0] mask;
    wire [1:0] mode = sh[4:3];
    // Shadow of software-owned bits; the low mode bit is hidden while the error view is on
    always @(posedge clk) begin
        if (!rst_b) begin
            sh <= 5'h00;
            cfg <= 3'h0;
            mask <= 3'h0;
        end else if (wr) begin
            if (addr == 8'h98 && !cfg[0]) sh[4] <= wdata[7];
            if (addr == 8'h98) sh[3:0] <= wdata[6:3];
            if (addr == 8'hA0) cfg <= wdata[2:0];
            if (addr == 8'hA2) mask <= wdata[2:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero after idle cycle");
    unmapped_read_a: assert property (rd && !(addr inside {8'h98, 8'h99, 8'hA0, 8'hA1, 8'hA2})
        |=> rdata == 8'h00) else $error("unmapped read not zero");
    config_read_a: assert property (rd && addr == 8'hA0 |=> rdata == {5'h00, $past(cfg)})
        else $error("config readback wrong");
    mask_read_a: assert property (rd && addr == 8'hA2 |=> rdata == {5'h00, $past(mask)})
        else $error("mask readback wrong");
    control_read_a: assert property (rd && addr == 8'h98 && !cfg[0] |=> rdata[7:3] == $past(sh))
        else $error("control mode bits wrong");
    tx_start_a: assert property (wr && addr == 8'h99 && mode != 2'h0 |=> !txd [*8])
        else $error("start bit missing after data write");
    async_oe_a: assert property (mode != 2'h0 |=> rxd_oe_b)
        else $error("data pin driven outside mode 0");
    sync_fast_a: assert property ($fell(txd) && mode == 2'h0 && sh[2] |=> !txd ##1 txd)
        else $error("fast shift clock half period wrong");
    sync_slow_a: assert property ($fell(txd) && mode == 2'h0 && !sh[2] |=> !txd [*5] ##1 txd)
        else $error("slow shift clock half period wrong");
    irq_gate_a: assert property (!cfg[1] || mask == 3'h0 |-> !irq)
        else $error("interrupt raised while gated");
endmodule // ucd_uart_asserts
bind ucd_uart ucd_uart_asserts #(.AW(AW), .DW(DW)) i_chk (.clk(clk), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_tick16(ext_tick16),
    .txd(txd), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_b(rxd_oe_b), .irq(irq));
